//--- cie_regs.vh
/*
 * cie_regs.vh: opcodes, flag and enable bit positions, error codes,
 * reset values and timing counts for the CAM instruction executor.
 * Assumes inclusion by bare name from the design file.
 */
`ifndef CIE_REGS_VH
`define CIE_REGS_VH

// opcodes (16 bit)
`define CIE_OP_INS_A    16'h0000
`define CIE_OP_INS_B    16'h000f
`define CIE_OP_DEL_A    16'h0001
`define CIE_OP_DEL_B    16'h000e
`define CIE_OP_MASK_A   16'h0002
`define CIE_OP_MASK_B   16'h000d
`define CIE_OP_COUNT    16'h0003
`define CIE_OP_FAST     16'h0004
`define CIE_OP_BUF      16'h0005
`define CIE_OP_CHECK    16'h0006
`define CIE_OP_AFULL    16'h0007
`define CIE_OP_ATM      16'h0008
`define CIE_OP_FRPTR    16'h0009
`define CIE_OP_FREAD    16'h000a
`define CIE_OP_INIT     16'h000b

// flag bit positions
`define CIE_FL_IEN      0
`define CIE_FL_HIT      1
`define CIE_FL_INIT     2
`define CIE_FL_BUF      3
`define CIE_FL_QEMPTY   4
`define CIE_FL_QFULL    5
`define CIE_FL_TFULL    6
`define CIE_FL_ERR      7
`define CIE_FL_AFULL    8
`define CIE_FL_ATM      9
`define CIE_FL_DONE     10

// interrupt enable bit positions
`define CIE_IE_QFULL    0
`define CIE_IE_TFULL    1
`define CIE_IE_CHECK    2
`define CIE_IE_INIT     3
`define CIE_IE_FAST     4
`define CIE_IE_AFULL    5
`define CIE_IE_FREAD    7

// error codes
`define CIE_ERR_NONE    16'hffff
`define CIE_ERR_BADOP   16'hfffd
`define CIE_ERR_FREAD   16'hfffc
`define CIE_ERR_FAST    16'hfffa
`define CIE_ERR_TFULL   16'hfff9
`define CIE_ERR_QFULL   16'hfff8

// reset values
`define CIE_FLAGS_RST   16'h001c
`define CIE_AFULL_RST   12'hfff

// sizes
`define CIE_DEPTH       4096
`define CIE_QDEPTH      12

// timing: check takes 16 cycles, init up to 18 ms at 100 MHz
`define CIE_CHECK_CYC   5'h10
`define CIE_INIT_MS     18
`define CIE_CLK_MHZ     100
`define CIE_INIT_CYC    (`CIE_INIT_MS * 1000 * `CIE_CLK_MHZ)

`endif

//--- cie_executor.v
/*
 * cie_executor.v: command interpreter for the control port of a
 * 4096 x 64 content-addressable memory. Holds the four holding
 * registers, the table, the entry queue, mask and pointers.
 * Assumes the host write strobes come from logic on clk_sys_i.
 */
`timescale 1ns/1ps
`default_nettype none
`include "cie_regs.vh"

// Functional notes
// - 64-bit operand is hold3..hold0, hold3 bit 15 is the msb.
// - buffered insert goes to first free queue slot, matchable at once.
// - buffered insert with queue full: no write, error fff8, enable bit 0.
// - fast-entry insert writes straight into the table array.
// - fast insert with table full: no write, error fff9, enable bit 1.
// - buffered insert with same pattern replaces the old entry.
// - delete compares unmasked bits and invalidates the matching entry.
// - check does masked compare, sets or clears hit, copies entry back.
// - check finishes in 16 cycles, interrupt if enable bit 2.
// - init sets initialized and buffered flags, interrupt if bit 3.
// - registers read-only for up to 18 ms during init.
// - fast mode only with queue empty, else error fffa, enable bit 4.
// - buffered mode accepted anytime; inserts use the queue, deletes too unless it is full, then the table entry is cleared.
// - mixed-mode loading hides all entries until init runs.
// - newest queued operation wins over table for one pattern.
// - entry count is table valid count plus queued inserts.
// - set mask copies operand; mask bit 1 excludes that bit.
// - almost-full point from hold0; a fast insert reaching it in the table sets bit 8, enable 5.
// - fast-read pointer takes low 12 bits of hold0.
// - fast read with queue not empty: error fffc, enable bit 7.
// - operands go to holding registers first; opcode write starts.
// - each opcode write clears error flag and error code to ffff.
// - sync reset held two cycles empties all, flags 1c, point fff.
module cie_executor #(
  parameter INIT_CYC = `CIE_INIT_CYC
) (
  // clock, reset, enable
  input  wire        clk_sys_i,
  input  wire        rst_b_i,
  input  wire        clk_en_i,
  // synchronous device reset, active low
  input  wire        sreset_b_i,
  // host writes
  input  wire        wr_hold_i,
  input  wire [1:0]  wr_hold_idx_i,
  input  wire        wr_op_i,
  input  wire        wr_ien_i,
  input  wire [15:0] wr_data_i,
  // register contents
  output reg  [15:0] hold0_o,
  output reg  [15:0] hold1_o,
  output reg  [15:0] hold2_o,
  output reg  [15:0] hold3_o,
  output reg  [15:0] flags_o,
  output reg  [15:0] err_code_o,
  output reg  [7:0]  ien_o,
  output reg  [11:0] afull_pt_o,
  output reg  [11:0] fr_ptr_o,
  output reg  [63:0] mask_o,
  output reg         irq_o
);

  // ****************************************************
  // state and storage
  // ****************************************************
  localparam ST_IDLE  = 2'd0;
  localparam ST_CHECK = 2'd1;
  localparam ST_INIT  = 2'd2;
  localparam ST_RST   = 2'd3;

  reg  [1:0]  state;
  reg  [4:0]  chk_cnt;
  reg  [31:0] init_cnt;
  reg  [11:0] clr_idx;
  reg         srst_q;
  reg         mixed;       // both entry modes used since last init
  reg         used_fast;
  reg         used_buf;
  reg  [12:0] tbl_cnt;
  reg  [3:0]  q_cnt;

  reg  [63:0] tbl     [0:`CIE_DEPTH-1];
  reg         tbl_vld [0:`CIE_DEPTH-1];
  // queue holds the newest op per pattern; ins=1 insert, 0 delete
  reg  [63:0] q_data  [0:`CIE_QDEPTH-1];
  reg         q_vld   [0:`CIE_QDEPTH-1];
  reg         q_ins   [0:`CIE_QDEPTH-1];

  wire [63:0] operand = {hold3_o, hold2_o, hold1_o, hold0_o};
  wire        q_full  = (q_cnt == `CIE_QDEPTH);
  wire        q_empty = (q_cnt == 4'h0);
  wire        t_full  = (tbl_cnt == `CIE_DEPTH);
  wire        busy    = (state != ST_IDLE);

  // ****************************************************
  // masked search over queue and table
  // ****************************************************
  integer     i;
  reg         q_hit;
  reg  [3:0]  q_hidx;
  reg  [3:0]  q_free;
  reg         q_fok;
  reg         t_hit;
  reg  [11:0] t_hidx;
  reg  [11:0] t_free;
  reg  [3:0]  q_ins_n;
  // combinational search; a real part would sweep this over cycles
  always @* begin
    q_hit = 1'b0; q_hidx = 4'h0; q_free = 4'h0; q_fok = 1'b0;
    t_hit = 1'b0; t_hidx = 12'h000; t_free = 12'h000; q_ins_n = 4'h0;
    for (i = `CIE_QDEPTH-1; i >= 0; i = i - 1) begin
      if (q_vld[i] && (((q_data[i] ^ operand) & ~mask_o) == 64'h0)) begin
        q_hit = 1'b1;
        q_hidx = i[3:0];
      end
      if (!q_vld[i]) begin
        q_fok = 1'b1;
        q_free = i[3:0];
      end
      if (q_vld[i] && q_ins[i])
        q_ins_n = q_ins_n + 4'h1;
    end
    for (i = `CIE_DEPTH-1; i >= 0; i = i - 1) begin
      if (tbl_vld[i] && (((tbl[i] ^ operand) & ~mask_o) == 64'h0)) begin
        t_hit = 1'b1;
        t_hidx = i[11:0];
      end
      if (!tbl_vld[i])
        t_free = i[11:0];
    end
  end

  // newest queued op wins, then table; mixed loading hides all
  wire        vis_q = q_hit && !mixed;
  wire        vis_t = !q_hit && t_hit && !mixed;
  wire        found = vis_q ? q_ins[q_hidx] : vis_t;
  wire [63:0] found_val = vis_q ? q_data[q_hidx] : tbl[t_hidx];

  // ****************************************************
  // command execution
  // ****************************************************
  integer j;
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= ST_RST; chk_cnt <= 5'h0; init_cnt <= 32'h0;
      clr_idx <= 12'h000; srst_q <= 1'b0; mixed <= 1'b0;
      used_fast <= 1'b0; used_buf <= 1'b0;
      tbl_cnt <= 13'h0; q_cnt <= 4'h0;
      hold0_o <= 16'h0; hold1_o <= 16'h0;
      hold2_o <= 16'h0; hold3_o <= 16'h0;
      flags_o <= `CIE_FLAGS_RST & ~16'h0400; err_code_o <= `CIE_ERR_NONE;
      ien_o <= 8'h00; afull_pt_o <= `CIE_AFULL_RST; fr_ptr_o <= 12'h000;
      mask_o <= 64'h0; irq_o <= 1'b0;
      for (j = 0; j < `CIE_QDEPTH; j = j + 1) begin
        q_vld[j] <= 1'b0; q_ins[j] <= 1'b0; q_data[j] <= 64'h0;
      end
    end else if (clk_en_i) begin
      srst_q <= !sreset_b_i;
      irq_o <= 1'b0;
      // queue and table flags track the counters, the any-enable flag the enable register
      flags_o[`CIE_FL_QEMPTY] <= q_empty;
      flags_o[`CIE_FL_QFULL]  <= q_full;
      flags_o[`CIE_FL_TFULL]  <= t_full;
      flags_o[`CIE_FL_IEN]    <= (ien_o != 8'h00);
      if (!sreset_b_i && srst_q) begin
        // second low cycle: start clearing table valid bits
        state <= ST_RST; clr_idx <= 12'h000;
        tbl_cnt <= 13'h0; q_cnt <= 4'h0; mixed <= 1'b0;
        used_fast <= 1'b0; used_buf <= 1'b0;
        flags_o <= `CIE_FLAGS_RST;
        err_code_o <= `CIE_ERR_NONE;
        ien_o <= 8'h00; afull_pt_o <= `CIE_AFULL_RST;
        for (j = 0; j < `CIE_QDEPTH; j = j + 1)
          q_vld[j] <= 1'b0;
      end else begin
        case (state)
          ST_RST: begin
            // sweep valid bits one per cycle; done flag held low meanwhile
            tbl_vld[clr_idx] <= 1'b0;
            clr_idx <= clr_idx + 12'h001;
            if (clr_idx == 12'hfff) begin
              state <= ST_IDLE;
              flags_o[`CIE_FL_DONE] <= 1'b1;
            end
          end
          ST_CHECK: begin
            chk_cnt <= chk_cnt + 5'h01;
            if (chk_cnt == `CIE_CHECK_CYC - 5'h02) begin
              flags_o[`CIE_FL_HIT] <= found;
              if (found) begin
                hold3_o <= found_val[63:48]; hold2_o <= found_val[47:32];
                hold1_o <= found_val[31:16]; hold0_o <= found_val[15:0];
              end
              irq_o <= ien_o[`CIE_IE_CHECK];
              flags_o[`CIE_FL_DONE] <= 1'b1;
              state <= ST_IDLE;
            end
          end
          ST_INIT: begin
            // registers stay read-only until the count ends
            init_cnt <= init_cnt + 32'h1;
            if (init_cnt == INIT_CYC - 1) begin
              // fold queued ops into the table is left to the sorter;
              // here only visibility is restored
              mixed <= 1'b0; used_fast <= 1'b0; used_buf <= 1'b0;
              flags_o[`CIE_FL_INIT] <= 1'b1;
              flags_o[`CIE_FL_BUF]  <= 1'b1;
              irq_o <= ien_o[`CIE_IE_INIT];
              flags_o[`CIE_FL_DONE] <= 1'b1;
              state <= ST_IDLE;
            end
          end
          default: begin
            if (wr_hold_i && !busy) begin
              if (wr_hold_idx_i == 2'd0) hold0_o <= wr_data_i;
              else if (wr_hold_idx_i == 2'd1) hold1_o <= wr_data_i;
              else if (wr_hold_idx_i == 2'd2) hold2_o <= wr_data_i;
              else hold3_o <= wr_data_i;
            end
            if (wr_ien_i)
              ien_o <= wr_data_i[7:0];
            if (wr_op_i) begin
              flags_o[`CIE_FL_ERR] <= 1'b0;
              err_code_o <= `CIE_ERR_NONE;
              flags_o[`CIE_FL_DONE] <= 1'b1;
              if (wr_data_i == `CIE_OP_INS_A || wr_data_i == `CIE_OP_INS_B) begin
                if (flags_o[`CIE_FL_BUF]) begin
                  if (q_hit) begin
                    // same pattern already queued: replace
                    q_data[q_hidx] <= operand; q_ins[q_hidx] <= 1'b1;
                  end else if (q_full || !q_fok) begin
                    err_code_o <= `CIE_ERR_QFULL;
                    flags_o[`CIE_FL_ERR] <= 1'b1;
                    irq_o <= ien_o[`CIE_IE_QFULL];
                  end else begin
                    q_data[q_free] <= operand; q_vld[q_free] <= 1'b1;
                    q_ins[q_free] <= 1'b1; q_cnt <= q_cnt + 4'h1;
                    used_buf <= 1'b1;
                    if (used_fast) mixed <= 1'b1;
                  end
                end else if (t_full) begin
                  err_code_o <= `CIE_ERR_TFULL;
                  flags_o[`CIE_FL_ERR] <= 1'b1;
                  irq_o <= ien_o[`CIE_IE_TFULL];
                end else begin
                  tbl[t_free] <= operand; tbl_vld[t_free] <= 1'b1;
                  tbl_cnt <= tbl_cnt + 13'h1;
                  used_fast <= 1'b1;
                  if (used_buf) mixed <= 1'b1;
                  if (tbl_cnt + 13'h1 == {1'b0, afull_pt_o}) begin
                    flags_o[`CIE_FL_AFULL] <= 1'b1;
                    irq_o <= ien_o[`CIE_IE_AFULL];
                  end
                end
              end else if (wr_data_i == `CIE_OP_DEL_A ||
                           wr_data_i == `CIE_OP_DEL_B) begin
                if (flags_o[`CIE_FL_BUF] && q_hit) begin
                  q_ins[q_hidx] <= 1'b0; // newest op is now a delete
                end else if (flags_o[`CIE_FL_BUF] && t_hit && q_fok) begin
                  q_data[q_free] <= operand; q_vld[q_free] <= 1'b1;
                  q_ins[q_free] <= 1'b0; q_cnt <= q_cnt + 4'h1;
                end else if (t_hit) begin
                  tbl_vld[t_hidx] <= 1'b0;
                  tbl_cnt <= tbl_cnt - 13'h1;
                end
              end else if (wr_data_i == `CIE_OP_CHECK) begin
                state <= ST_CHECK; chk_cnt <= 5'h0;
                flags_o[`CIE_FL_DONE] <= 1'b0;
              end else if (wr_data_i == `CIE_OP_INIT) begin
                state <= ST_INIT; init_cnt <= 32'h0;
                flags_o[`CIE_FL_DONE] <= 1'b0;
              end else if (wr_data_i == `CIE_OP_FAST) begin
                if (q_empty) begin
                  flags_o[`CIE_FL_BUF] <= 1'b0;
                  flags_o[`CIE_FL_INIT] <= 1'b0;
                end else begin
                  err_code_o <= `CIE_ERR_FAST;
                  flags_o[`CIE_FL_ERR] <= 1'b1;
                  irq_o <= ien_o[`CIE_IE_FAST];
                end
              end else if (wr_data_i == `CIE_OP_BUF) begin
                flags_o[`CIE_FL_BUF] <= 1'b1;
              end else if (wr_data_i == `CIE_OP_COUNT) begin
                // table count is 13 bits; widened on purpose to the register
                hold0_o <= {3'b000, tbl_cnt + {9'h000, q_ins_n}};
              end else if (wr_data_i == `CIE_OP_MASK_A ||
                           wr_data_i == `CIE_OP_MASK_B) begin
                mask_o <= operand;
              end else if (wr_data_i == `CIE_OP_AFULL) begin
                afull_pt_o <= hold0_o[11:0];
              end else if (wr_data_i == `CIE_OP_FRPTR) begin
                fr_ptr_o <= hold0_o[11:0];
              end else if (wr_data_i == `CIE_OP_FREAD) begin
                if (!q_empty) begin
                  err_code_o <= `CIE_ERR_FREAD;
                  flags_o[`CIE_FL_ERR] <= 1'b1;
                  irq_o <= ien_o[`CIE_IE_FREAD];
                end else begin
                  hold3_o <= tbl[fr_ptr_o][63:48];
                  hold2_o <= tbl[fr_ptr_o][47:32];
                  hold1_o <= tbl[fr_ptr_o][31:16];
                  hold0_o <= tbl[fr_ptr_o][15:0];
                  fr_ptr_o <= fr_ptr_o + 12'h001;
                end
              end else if (wr_data_i == `CIE_OP_ATM) begin
                flags_o[`CIE_FL_ATM] <= 1'b1;
              end else begin
                err_code_o <= `CIE_ERR_BADOP;
                flags_o[`CIE_FL_ERR] <= 1'b1;
                irq_o <= ien_o[`CIE_IE_FREAD];
              end
            end
          end
        endcase
      end
    end
  end

endmodule // cie_executor
`default_nettype wire

//--- cie_executor_monitor.sv
/* cie_executor_monitor.sv: port assertions for cie_executor.
   assumes one clock, async low reset, done is flags bit 10. */
`timescale 1ns/1ps
`default_nettype none
`include "cie_regs.vh"
// ****************************************************************
// checker
// ****************************************************************
module cie_executor_mon (
  // clock and reset
  input wire logic        clk_sys_i,
  input wire logic        rst_b_i,
  // enable, sync reset and host writes
  input wire logic        clk_en_i,
  input wire logic        sreset_b_i,
  input wire logic        wr_op_i,
  input wire logic [15:0] wr_data_i,
  // register contents
  input wire logic [15:0] hold0_o,
  input wire logic [15:0] hold1_o,
  input wire logic [15:0] hold2_o,
  input wire logic [15:0] hold3_o,
  input wire logic [15:0] flags_o,
  input wire logic [15:0] err_code_o,
  input wire logic [7:0]  ien_o,
  input wire logic [11:0] afull_pt_o,
  input wire logic [11:0] fr_ptr_o,
  input wire logic [63:0] mask_o,
  input wire logic        irq_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  // an opcode only counts when the executor is idle and not held
  wire logic        go   = clk_en_i & sreset_b_i & wr_op_i & flags_o[10];
  wire logic [63:0] opnd = {hold3_o, hold2_o, hold1_o, hold0_o};
  sequence s_chk;
    go && wr_data_i == `CIE_OP_CHECK;
  endsequence
  sequence s_busy;
    (!flags_o[10])[*7];
  endsequence
  sequence s_srst;
    clk_en_i && !sreset_b_i ##1 clk_en_i && !sreset_b_i;
  endsequence
  chk_timing_a: assert property (s_chk |-> ##1 s_busy ##1 s_busy ##1 !flags_o[10] ##1 flags_o[10])
    else $error("check op did not finish on cycle 16");
  chk_irq_a: assert property (s_chk and ien_o[2] |-> ##16 irq_o)
    else $error("check op raised no interrupt");
  op_clr_a: assert property (s_chk |=> err_code_o == `CIE_ERR_NONE && !flags_o[7])
    else $error("opcode write left an error standing");
  err_pair_a: assert property (flags_o[7] == (err_code_o != `CIE_ERR_NONE))
    else $error("error flag and error code disagree");
  mask_ld_a: assert property (go && wr_data_i == `CIE_OP_MASK_A |=> mask_o == $past(opnd))
    else $error("mask not loaded from holding registers");
  afpt_ld_a: assert property (go && wr_data_i == `CIE_OP_AFULL |=> afull_pt_o == $past(hold0_o[11:0]))
    else $error("almost full point not loaded");
  frptr_ld_a: assert property (go && wr_data_i == `CIE_OP_FRPTR |=> fr_ptr_o == $past(hold0_o[11:0]))
    else $error("fast read pointer not loaded");
  fast_bad_a: assert property (go && wr_data_i == `CIE_OP_FAST && !flags_o[4] |=> err_code_o == `CIE_ERR_FAST && flags_o[7])
    else $error("fast mode with queue busy not refused");
  fast_ok_a: assert property (go && wr_data_i == `CIE_OP_FAST && flags_o[4] |=> flags_o[3:2] == 2'b00)
    else $error("fast mode entry left mode bits set");
  qfull_ins_a: assert property (go && wr_data_i == `CIE_OP_INS_A && flags_o[5] && flags_o[3] |=> err_code_o == `CIE_ERR_QFULL)
    else $error("insert into full queue not refused");
  sreset_val_a: assert property (s_srst |=> err_code_o == `CIE_ERR_NONE && ien_o == 8'h00 && afull_pt_o == 12'hfff && flags_o[9:0] == 10'h01c)
    else $error("sync reset values wrong");
endmodule // cie_executor_mon
bind cie_executor cie_executor_mon u_mon (.clk_sys_i, .rst_b_i, .clk_en_i,
  .sreset_b_i, .wr_op_i, .wr_data_i, .hold0_o, .hold1_o, .hold2_o, .hold3_o,
  .flags_o, .err_code_o, .ien_o, .afull_pt_o, .fr_ptr_o, .mask_o, .irq_o);
`default_nettype wire

//--- cie_host_model.sv
/* cie_host_model.sv: host writing the control port of cie_executor.
   assumes strobes one cycle wide on clk_sys_i, done is flags bit 10. */
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// host model
// ****************************************************************
module cie_host_model (
  // clock and status
  input  wire logic        clk_sys_i,
  input  wire logic [15:0] flags_i,
  // write strobes
  output var  logic        wr_hold_o,
  output var  logic [1:0]  wr_hold_idx_o,
  output var  logic        wr_op_o,
  output var  logic        wr_ien_o,
  output var  logic [15:0] wr_data_o
);
  int gap = 0;
  int stalls = 0;
  initial begin
    {wr_hold_o, wr_op_o, wr_ien_o, wr_hold_idx_o} = 5'h00;
    wr_data_o = 16'h0000;
  end
  // one strobe; data is inverted after, so stale data is never trusted
  task automatic strobe(input logic [2:0] kind, input logic [1:0] idx,
                        input logic [15:0] d);
    repeat (gap) @(posedge clk_sys_i);
    @(posedge clk_sys_i);
    wr_hold_o     <= kind[0];
    wr_op_o       <= kind[1];
    wr_ien_o      <= kind[2];
    wr_hold_idx_o <= idx;
    wr_data_o     <= d;
    @(posedge clk_sys_i);
    {wr_ien_o, wr_op_o, wr_hold_o} <= 3'h0;
    wr_data_o     <= ~d;
    #1;
  endtask
  // operand words first, then the opcode; wait on done with a bound
  task automatic run(input logic [63:0] v, input logic [15:0] code,
                     input int lim);
    int n;
    for (int i = 0; i < 4; i++)
      strobe(3'h1, i[1:0], v[16*i +: 16]);
    strobe(3'h2, 2'h0, code);
    n = 0;
    while (flags_i[10] !== 1'b1 && n < lim) begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end
    if (n >= lim)
      stalls++;
  endtask
  task automatic ien(input logic [7:0] e);
    strobe(3'h4, 2'h0, {8'h00, e});
  endtask
endmodule // cie_host_model
`default_nettype wire

//--- cie_executor_tb.sv
/* cie_executor_tb.sv: self-checking bench for cie_executor.
   assumes the host model drives writes; init count is shortened. */
`timescale 1ns/1ps
`default_nettype none
`include "cie_regs.vh"
// ****************************************************************
// testbench
// ****************************************************************
module cie_executor_tb;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic srst_b = 1'b1;
  logic en = 1'b1;
  wire logic        w_hold, w_op, w_ien, irq;
  wire logic [1:0]  w_idx;
  wire logic [15:0] w_data, h0, h1, h2, h3, flags, err;
  wire logic [7:0]  ien;
  wire logic [11:0] afpt, frp;
  wire logic [63:0] mask;
  int miscompares = 0;
  int checked = 0;
  int irqs = 0;
  int seed = 71608;
  logic [63:0] v [0:2];
  logic [63:0] t;
  cie_executor #(.INIT_CYC(20)) u_dut (.clk_sys_i(clk), .rst_b_i(rst_b),
    .clk_en_i(en), .sreset_b_i(srst_b), .wr_hold_i(w_hold),
    .wr_hold_idx_i(w_idx), .wr_op_i(w_op), .wr_ien_i(w_ien),
    .wr_data_i(w_data), .hold0_o(h0), .hold1_o(h1), .hold2_o(h2),
    .hold3_o(h3), .flags_o(flags), .err_code_o(err), .ien_o(ien),
    .afull_pt_o(afpt), .fr_ptr_o(frp), .mask_o(mask), .irq_o(irq));
  cie_host_model u_host (.clk_sys_i(clk), .flags_i(flags),
    .wr_hold_o(w_hold), .wr_hold_idx_o(w_idx), .wr_op_o(w_op),
    .wr_ien_o(w_ien), .wr_data_o(w_data));
  initial forever #5 clk = ~clk;
  // edge count: pulses are never back to back in these tests
  always @(posedge irq) irqs++;
  task automatic chk(input string nm, input logic [63:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic finish_test;
    miscompares += u_host.stalls;
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // random entry with a distinct top byte so patterns never collide
  function automatic logic [63:0] rv(input int k);
    rv = {$random(seed), $random(seed)};
    rv[63:56] = k[7:0];
  endfunction
  task automatic settle;
    for (int n = 0; n < 6000 && flags[10] !== 1'b1; n++)
      @(posedge clk);
    #1;
  endtask
  initial begin
    repeat (40000) @(posedge clk);
    miscompares++;
    finish_test();
  end
  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    settle();
    chk("flags", flags, 16'h041c);
    chk("err", err, `CIE_ERR_NONE);
    $display("test reset done");
    u_host.ien(8'hff);
    // the any-enable flag follows the enable register one cycle later
    @(posedge clk);
    #1;
    chk("ien flag", flags[0], 1'b1);
    t = 64'h0000_0000_ffff_ffff; // mask set before entries
    u_host.run(t, `CIE_OP_MASK_A, 8);
    chk("mask", mask, t);
    for (int i = 0; i < 3; i++) begin
      v[i] = rv(i);
      u_host.run(v[i], `CIE_OP_INS_A, 8);
    end
    v[0][31:0] = ~v[0][31:0];
    u_host.run(v[0], `CIE_OP_INS_B, 8);
    u_host.run(t, `CIE_OP_COUNT, 8);
    chk("count", h0, 16'h0003);
    u_host.run({v[0][63:32], 32'h0}, `CIE_OP_CHECK, 40);
    chk("hit", flags[1], 1'b1);
    chk("check data", {h3, h2, h1, h0}, v[0]);
    u_host.run(v[1] ^ 64'h5a5a, `CIE_OP_DEL_B, 8);
    u_host.run(v[1], `CIE_OP_CHECK, 40);
    chk("miss", flags[1], 1'b0);
    chk("irqs", irqs, 2);
    // three slots in use; nine more fill the twelve-deep queue exactly
    for (int i = 3; i < 12; i++)
      u_host.run(rv(i), `CIE_OP_INS_A, 8);
    @(posedge clk);
    #1;
    chk("qfull", flags[5], 1'b1);
    u_host.run(rv(20), `CIE_OP_INS_A, 8);
    chk("qfull err", err, `CIE_ERR_QFULL);
    chk("err flag", flags[7], 1'b1);
    u_host.run(t, `CIE_OP_FAST, 8);
    chk("fast err", err, `CIE_ERR_FAST);
    chk("mode", flags[3], 1'b1);
    u_host.run(t, `CIE_OP_FREAD, 8);
    chk("fread err", err, `CIE_ERR_FREAD);
    u_host.run(t, `CIE_OP_BUF, 8);
    chk("err clr", err, `CIE_ERR_NONE);
    chk("irqs", irqs, 5);
    $display("test buffered done");
    @(posedge clk);
    srst_b <= 1'b0;
    repeat (2) @(posedge clk);
    srst_b <= 1'b1;
    #1;
    chk("sreset ien", ien, 8'h00);
    chk("sreset afpt", afpt, 12'hfff);
    settle();
    chk("sreset flags", flags, 16'h041c);
    u_host.gap = 2; // slow host from here on
    u_host.ien(8'hff);
    u_host.run(t, `CIE_OP_MASK_B, 8);
    chk("mask b", mask, t);
    u_host.run(64'h2, `CIE_OP_AFULL, 8);
    chk("afpt", afpt, 12'h002);
    u_host.run(64'hfbc5, `CIE_OP_FRPTR, 8);
    chk("frptr", frp, 12'hbc5);
    u_host.run(t, `CIE_OP_FAST, 8);
    chk("fast mode", flags[3:2], 2'b00);
    irqs = 0;
    for (int i = 0; i < 2; i++) begin
      v[i] = rv(30 + i); // distinct patterns only
      u_host.run(v[i], `CIE_OP_INS_A, 8);
      chk("afull", flags[8], i == 1);
    end
    u_host.run(t, `CIE_OP_INIT, 60);
    chk("init flags", flags[3:2], 2'b11);
    u_host.run(v[1], `CIE_OP_CHECK, 40);
    chk("fast hit", {h3, h2, h1, h0}, v[1]);
    chk("irqs", irqs, 3);
    $display("test fast done");
    finish_test();
  end
endmodule // cie_executor_tb
`default_nettype wire
